// ===== common/sbr_pkg.sv
// Operation
// R01 - high write only buffered; working divisor updates on low write
// R02 - divisor is high bits 4:0 above all eight low bits
// R03 - divisor of zero stops the generator, no ticks at all
// R04 - bit rate equals bus clock over sixteen times divisor
// R05 - generator idles after reset until receiver or transmitter enabled
// R06 - high bit 7 lets the break-detect flag raise the interrupt
// R07 - high bit 6 lets the receive-edge flag raise the interrupt
// R08 - optional 13-bit break sent, 11-bit low line detected as break
// R09 - eight or nine data bits; double-buffered tx and rx, separate enables
// R10 - full-duplex NRZ on both ends; hardware parity generate and check
// R11 - receiver wakes on idle line or address mark; selectable tx polarity
// R12 - sixteen-times tick for receiver, divided by sixteen for transmit bits
package sbr_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam int unsigned DIV_W = 13;
   localparam logic [7:0] OFF_DIV_HIGH = 8'h40;
   localparam logic [7:0] OFF_DIV_LOW = 8'h41;
   localparam logic [7:0] RST_DIV_HIGH = 8'h00;
   localparam logic [7:0] RST_DIV_LOW = 8'h04;
   localparam int unsigned BIT_BRK_IE = 7;
   localparam int unsigned BIT_EDGE_IE = 6;
   localparam int unsigned HI_DIV_MSB = 4;
   localparam logic [7:0] HI_WR_MASK = 8'hdf;
   // ------------------------------------------------------------
   // timing counts
   // ------------------------------------------------------------
   localparam int unsigned OVERSAMPLE = 16;
   localparam logic [3:0] OSR_LAST = 4'(OVERSAMPLE - 1);
   localparam logic [3:0] OSR_MID = 4'(OVERSAMPLE / 2 - 1);
   localparam int unsigned BRK_TX_BITS = 13;
   localparam int unsigned BRK_RX_BITS = 11;
   localparam int unsigned FRAME_BITS_8 = 10;
   localparam int unsigned FRAME_BITS_9 = 11;
   localparam logic [3:0] TX_BRK_CNT = 4'(BRK_TX_BITS);
   localparam logic [3:0] TX_FRM_CNT_8 = 4'(FRAME_BITS_8);
   localparam logic [3:0] TX_FRM_CNT_9 = 4'(FRAME_BITS_9);
   localparam logic [7:0] RX_BRK_TICKS = 8'(BRK_RX_BITS * OVERSAMPLE);
   localparam logic [7:0] RX_IDLE_8 = 8'(FRAME_BITS_8 * OVERSAMPLE);
   localparam logic [7:0] RX_IDLE_9 = 8'(FRAME_BITS_9 * OVERSAMPLE);
   localparam int unsigned RX_WORD_W = 11;
   // ------------------------------------------------------------
   // state machines
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      SBR_TX_IDLE = 3'b001,
      SBR_TX_FRAME = 3'b010,
      SBR_TX_BREAK = 3'b100
   } sbr_tx_state_e;
   typedef enum logic [3:0] {
      SBR_RX_IDLE = 4'b0001,
      SBR_RX_START = 4'b0010,
      SBR_RX_DATA = 4'b0100,
      SBR_RX_STOP = 4'b1000
   } sbr_rx_state_e;
endpackage

// ===== common/sbr_baud_if.sv
`timescale 1ns/10ps
interface sbr_baud_if;
   logic [sbr_pkg::DIV_W-1:0] divisor;
   logic run;
   logic tick16;
   logic tick_bit;
   modport gen (input divisor, input run, output tick16, output tick_bit);
   modport user (output divisor, output run, input tick16, input tick_bit);
endinterface

// ===== rtl/sbr_baud_gen.sv
`timescale 1ns/10ps
module sbr_baud_gen #(
   parameter int unsigned DIV_W = sbr_pkg::DIV_W
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // tick port
   sbr_baud_if.gen bp
);
   import sbr_pkg::*;
   logic [DIV_W-1:0] cnt_r, cnt_nxt;
   logic [3:0] phase_r, phase_nxt;
   logic t16_r, t16_nxt;
   logic tb_r, tb_nxt;
   // ------------------------------------------------------------
   // modulo divider
   // ------------------------------------------------------------
   always_comb begin
      cnt_nxt = cnt_r + DIV_W'(1);
      phase_nxt = phase_r;
      t16_nxt = 1'b0;
      tb_nxt = 1'b0;
      if (!bp.run) begin
         // counters frozen at zero, nothing toggles [R03]
         cnt_nxt = '0;
         phase_nxt = 4'h0;
      end else if (cnt_r >= bp.divisor - DIV_W'(1)) begin
         // one tick every divisor clocks [R04] [R12]
         cnt_nxt = '0;
         t16_nxt = 1'b1;
         phase_nxt = phase_r + 4'h1;
         tb_nxt = (phase_r == OSR_LAST); // [R12]
      end
   end
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         cnt_r <= '0;
         phase_r <= 4'h0;
         t16_r <= 1'b0;
         tb_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         phase_r <= phase_nxt;
         t16_r <= t16_nxt;
         tb_r <= tb_nxt;
      end
   end
   assign bp.tick16 = t16_r;
   assign bp.tick_bit = tb_r;
endmodule

// ===== rtl/sbr_buf2.sv
`timescale 1ns/10ps
module sbr_buf2 #(
   parameter int unsigned W = sbr_pkg::RX_WORD_W
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // fill side
   input wire logic in_valid_in,
   input wire logic [W-1:0] in_data_in,
   output logic in_ready_out,
   // drain side
   output logic out_valid_out,
   output logic [W-1:0] out_data_out,
   input wire logic out_ready_in
);
   logic [W-1:0] d0_r, d0_nxt, d1_r, d1_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic push, pop;
   // ------------------------------------------------------------
   // two-slot queue, head slot drives the output
   // ------------------------------------------------------------
   always_comb begin
      push = in_valid_in && in_ready_out;
      pop = out_valid_out && out_ready_in;
      d0_nxt = d0_r;
      d1_nxt = d1_r;
      cnt_nxt = cnt_r;
      if (push && !pop) begin
         if (cnt_r == 2'd0) d0_nxt = in_data_in;
         else d1_nxt = in_data_in;
         cnt_nxt = cnt_r + 2'd1;
      end else if (pop && !push) begin
         d0_nxt = d1_r;
         cnt_nxt = cnt_r - 2'd1;
      end else if (pop && push) begin
         if (cnt_r == 2'd1) begin
            d0_nxt = in_data_in;
         end else begin
            d0_nxt = d1_r;
            d1_nxt = in_data_in;
         end
      end
   end
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         d0_r <= '0;
         d1_r <= '0;
         cnt_r <= 2'd0;
         out_valid_out <= 1'b0;
         in_ready_out <= 1'b1;
      end else begin
         d0_r <= d0_nxt;
         d1_r <= d1_nxt;
         cnt_r <= cnt_nxt;
         out_valid_out <= (cnt_nxt != 2'd0);
         in_ready_out <= (cnt_nxt != 2'd2);
      end
   end
   assign out_data_out = d0_r;
endmodule

// ===== rtl/sbr_baud_setup.sv
`timescale 1ns/10ps
module sbr_baud_setup (
   // clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   // control bits held by neighbouring registers
   input wire logic receiver_enable_in,
   input wire logic transmitter_enable_in,
   input wire logic nine_bit_in,
   input wire logic parity_en_in,
   input wire logic parity_odd_in,
   input wire logic tx_invert_in,
   input wire logic send_break_in,
   input wire logic wake_addr_mark_in,
   input wire logic rx_sleep_in,
   input wire logic break_flag_clr_in,
   input wire logic edge_flag_clr_in,
   // transmit stream
   input wire logic [8:0] tx_data_in,
   input wire logic tx_valid_in,
   output logic tx_ready_out,
   // receive stream
   output logic [8:0] rx_data_out,
   output logic rx_parity_err_out,
   output logic rx_frame_err_out,
   output logic rx_valid_out,
   input wire logic rx_ready_in,
   // serial pins
   input wire logic rx_pin_in,
   output logic tx_pin_out,
   // status
   output logic break_detect_flag_out,
   output logic rx_edge_flag_out,
   output logic rx_overrun_out,
   output logic irq_out
);
   import sbr_pkg::*;
   sbr_baud_if baud ();
   // ------------------------------------------------------------
   // divisor registers
   // ------------------------------------------------------------
   logic [7:0] hi_buf_r, hi_buf_nxt, rdata_r, rdata_nxt;
   logic [DIV_W-1:0] div_r, div_nxt;
   logic started_r, started_nxt;
   always_comb begin
      hi_buf_nxt = hi_buf_r;
      div_nxt = div_r;
      rdata_nxt = 8'h00;
      started_nxt = started_r | receiver_enable_in | transmitter_enable_in;
      if (reg_wr_in && reg_addr_in == OFF_DIV_HIGH)
         hi_buf_nxt = reg_wdata_in & HI_WR_MASK; // [R01]
      if (reg_wr_in && reg_addr_in == OFF_DIV_LOW)
         div_nxt = {hi_buf_r[HI_DIV_MSB:0], reg_wdata_in}; // [R01] [R02]
      if (reg_rd_in && reg_addr_in == OFF_DIV_HIGH)
         rdata_nxt = {hi_buf_r[7:5], div_r[DIV_W-1:8]};
      else if (reg_rd_in && reg_addr_in == OFF_DIV_LOW)
         rdata_nxt = div_r[7:0];
   end
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         hi_buf_r <= RST_DIV_HIGH;
         div_r <= {RST_DIV_HIGH[HI_DIV_MSB:0], RST_DIV_LOW};
         rdata_r <= 8'h00;
         started_r <= 1'b0;
      end else begin
         hi_buf_r <= hi_buf_nxt;
         div_r <= div_nxt;
         rdata_r <= rdata_nxt;
         started_r <= started_nxt;
      end
   end
   assign reg_rdata_out = rdata_r;
   // non-zero reset divisor must not start the clock on its own [R05]
   assign baud.run = started_r && (div_r != '0); // [R03] [R05]
   assign baud.divisor = div_r;
   sbr_baud_gen #(.DIV_W(DIV_W)) u_gen (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .bp(baud.gen)
   );
   // ------------------------------------------------------------
   // transmitter
   // ------------------------------------------------------------
   function automatic logic [10:0] build_frame(input logic [8:0] d,
         input logic nine, input logic pen, input logic podd);
      logic [8:0] w;
      w = d;
      // msb of the character carries parity [R10]
      if (pen && nine) w[8] = (^d[7:0]) ^ podd;
      else if (pen) w[7] = (^d[6:0]) ^ podd;
      if (nine) build_frame = {1'b1, w, 1'b0};
      else build_frame = {2'b11, w[7:0], 1'b0};
   endfunction
   sbr_tx_state_e tx_state_r, tx_state_nxt;
   logic [8:0] hold_r, hold_nxt;
   logic hold_full_r, hold_full_nxt, tx_ready_r;
   logic [10:0] shift_r, shift_nxt;
   logic [3:0] tx_cnt_r, tx_cnt_nxt;
   logic tx_line_r, tx_line_nxt;
   always_comb begin
      tx_state_nxt = tx_state_r;
      hold_nxt = hold_r;
      hold_full_nxt = hold_full_r;
      shift_nxt = shift_r;
      tx_cnt_nxt = tx_cnt_r;
      if (tx_valid_in && tx_ready_r) begin
         hold_nxt = tx_data_in; // first stage of double buffer, ahead of the shift register [R09]
         hold_full_nxt = 1'b1;
      end
      unique case (tx_state_r)
         SBR_TX_IDLE: begin
            if (transmitter_enable_in && baud.tick_bit) begin
               if (send_break_in) begin
                  tx_state_nxt = SBR_TX_BREAK;
                  tx_cnt_nxt = TX_BRK_CNT; // [R08]
               end else if (hold_full_r) begin
                  tx_state_nxt = SBR_TX_FRAME;
                  shift_nxt = build_frame(hold_r, nine_bit_in,
                     parity_en_in, parity_odd_in); // [R10]
                  tx_cnt_nxt = nine_bit_in ? TX_FRM_CNT_9
                     : TX_FRM_CNT_8; // [R09]
                  hold_full_nxt = 1'b0;
               end
            end
         end
         SBR_TX_FRAME, SBR_TX_BREAK: begin
            if (baud.tick_bit) begin // [R12]
               shift_nxt = {1'b1, shift_r[10:1]};
               tx_cnt_nxt = tx_cnt_r - 4'h1;
               if (tx_cnt_r == 4'h1) tx_state_nxt = SBR_TX_IDLE;
            end
         end
         default: tx_state_nxt = SBR_TX_IDLE;
      endcase
      // NRZ level, optionally inverted at the pin [R10] [R11]
      if (tx_state_nxt == SBR_TX_FRAME) tx_line_nxt = shift_nxt[0];
      else tx_line_nxt = (tx_state_nxt != SBR_TX_BREAK);
      tx_line_nxt = tx_line_nxt ^ tx_invert_in; // [R11]
   end
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         tx_state_r <= SBR_TX_IDLE;
         hold_r <= 9'h000;
         hold_full_r <= 1'b0;
         tx_ready_r <= 1'b1;
         shift_r <= 11'h7ff;
         tx_cnt_r <= 4'h0;
         tx_line_r <= 1'b1;
      end else begin
         tx_state_r <= tx_state_nxt;
         hold_r <= hold_nxt;
         hold_full_r <= hold_full_nxt;
         tx_ready_r <= !hold_full_nxt;
         shift_r <= shift_nxt;
         tx_cnt_r <= tx_cnt_nxt;
         tx_line_r <= tx_line_nxt;
      end
   end
   assign tx_ready_out = tx_ready_r;
   assign tx_pin_out = tx_line_r;
   // ------------------------------------------------------------
   // receiver
   // ------------------------------------------------------------
   sbr_rx_state_e rx_state_r, rx_state_nxt;
   logic rx_s1_r, rx_s2_r, rx_s3_r;
   logic [3:0] phase_r, phase_nxt, nbit_r, nbit_nxt;
   logic [8:0] rx_sh_r, rx_sh_nxt, word;
   logic [7:0] low_cnt_r, low_cnt_nxt, idle_cnt_r, idle_cnt_nxt;
   logic brk_r, brk_nxt, edge_r, edge_nxt, irq_r, irq_nxt;
   logic asleep_r, asleep_nxt, ovr_r, ovr_nxt;
   logic done, push, ferr, perr, buf_ready, mark;
   always_comb begin
      rx_state_nxt = rx_state_r;
      phase_nxt = phase_r;
      nbit_nxt = nbit_r;
      rx_sh_nxt = rx_sh_r;
      done = 1'b0;
      word = nine_bit_in ? rx_sh_r : {1'b0, rx_sh_r[8:1]};
      ferr = !rx_s2_r;
      perr = parity_en_in && ((^word) != parity_odd_in); // [R10]
      mark = nine_bit_in ? word[8] : word[7];
      if (baud.tick16) phase_nxt = phase_r + 4'h1; // [R12]
      unique case (rx_state_r)
         SBR_RX_IDLE: begin
            phase_nxt = 4'h0;
            if (receiver_enable_in && !rx_s2_r)
               rx_state_nxt = SBR_RX_START; // [R09]
         end
         SBR_RX_START: begin
            if (baud.tick16 && phase_r == OSR_MID) begin
               phase_nxt = 4'h0;
               nbit_nxt = 4'h0;
               rx_state_nxt = rx_s2_r ? SBR_RX_IDLE : SBR_RX_DATA;
            end
         end
         SBR_RX_DATA: begin
            if (baud.tick16 && phase_r == OSR_LAST) begin
               rx_sh_nxt = {rx_s2_r, rx_sh_r[8:1]};
               nbit_nxt = nbit_r + 4'h1;
               if (nbit_r == (nine_bit_in ? 4'h8 : 4'h7))
                  rx_state_nxt = SBR_RX_STOP; // [R09]
            end
         end
         SBR_RX_STOP: begin
            if (baud.tick16 && phase_r == OSR_LAST) begin
               done = 1'b1;
               rx_state_nxt = SBR_RX_IDLE;
            end
         end
         default: rx_state_nxt = SBR_RX_IDLE;
      endcase
      // sleeping receiver drops all but address marks in address-mark wake mode, and every word otherwise [R11]
      push = done && (!asleep_r || (wake_addr_mark_in && mark));
      ovr_nxt = push && !buf_ready;
      // low line time, counted in oversample ticks [R08]
      low_cnt_nxt = low_cnt_r;
      if (rx_s2_r || !receiver_enable_in) low_cnt_nxt = 8'h00;
      else if (baud.tick16 && low_cnt_r != RX_BRK_TICKS)
         low_cnt_nxt = low_cnt_r + 8'h01;
      idle_cnt_nxt = idle_cnt_r;
      if (!rx_s2_r || rx_state_r != SBR_RX_IDLE) idle_cnt_nxt = 8'h00;
      else if (baud.tick16 && idle_cnt_r != RX_IDLE_9)
         idle_cnt_nxt = idle_cnt_r + 8'h01;
      asleep_nxt = asleep_r;
      if (!wake_addr_mark_in && idle_cnt_r ==
            (nine_bit_in ? RX_IDLE_9 : RX_IDLE_8))
         asleep_nxt = 1'b0; // [R11]
      if (push) asleep_nxt = 1'b0; // [R11]
      if (rx_sleep_in) asleep_nxt = 1'b1;
      // hardware set wins over the clear
      brk_nxt = (brk_r && !break_flag_clr_in)
         || (low_cnt_r != RX_BRK_TICKS && low_cnt_nxt == RX_BRK_TICKS);
      edge_nxt = (edge_r && !edge_flag_clr_in)
         || (receiver_enable_in && rx_s3_r && !rx_s2_r);
      irq_nxt = (brk_nxt && hi_buf_nxt[BIT_BRK_IE]) // [R06]
         || (edge_nxt && hi_buf_nxt[BIT_EDGE_IE]); // [R07]
   end
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         rx_state_r <= SBR_RX_IDLE;
         {rx_s1_r, rx_s2_r, rx_s3_r} <= 3'b111;
         phase_r <= 4'h0;
         nbit_r <= 4'h0;
         rx_sh_r <= 9'h000;
         low_cnt_r <= 8'h00;
         idle_cnt_r <= 8'h00;
         {brk_r, edge_r, irq_r, asleep_r, ovr_r} <= 5'h00;
      end else begin
         rx_state_r <= rx_state_nxt;
         rx_s1_r <= rx_pin_in;
         rx_s2_r <= rx_s1_r;
         rx_s3_r <= rx_s2_r;
         phase_r <= phase_nxt;
         nbit_r <= nbit_nxt;
         rx_sh_r <= rx_sh_nxt;
         low_cnt_r <= low_cnt_nxt;
         idle_cnt_r <= idle_cnt_nxt;
         brk_r <= brk_nxt;
         edge_r <= edge_nxt;
         irq_r <= irq_nxt;
         asleep_r <= asleep_nxt;
         ovr_r <= ovr_nxt;
      end
   end
   // a full buffer rejects the word and raises overrun
   sbr_buf2 #(.W(RX_WORD_W)) u_rxbuf (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .in_valid_in(push),
      .in_data_in({ferr, perr, word}),
      .in_ready_out(buf_ready),
      .out_valid_out(rx_valid_out),
      .out_data_out({rx_frame_err_out, rx_parity_err_out, rx_data_out}),
      .out_ready_in(rx_ready_in)
   );
   assign break_detect_flag_out = brk_r;
   assign rx_edge_flag_out = edge_r;
   assign rx_overrun_out = ovr_r;
   assign irq_out = irq_r;
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);
   sequence s_low_write;
      reg_wr_in && reg_addr_in == OFF_DIV_LOW;
   endsequence
   sequence s_high_write;
      reg_wr_in && reg_addr_in == OFF_DIV_HIGH;
   endsequence
   sequence s_zero_held;
      (div_r == '0) [*2];
   endsequence
   property p_div_commit;
      s_low_write |=> div_r ==
         {$past(hi_buf_r[HI_DIV_MSB:0]), $past(reg_wdata_in)};
   endproperty
   a_div_commit: assert property (p_div_commit) // [R01] [R02]
      else $error("divisor not committed on low write");
   property p_high_buffered;
      s_high_write |=> $stable(div_r);
   endproperty
   a_high_buffered: assert property (p_high_buffered) // [R01]
      else $error("high write changed working divisor");
   property p_zero_stop;
      s_zero_held |-> !baud.tick16 && !baud.tick_bit;
   endproperty
   a_zero_stop: assert property (p_zero_stop) // [R03]
      else $error("tick with zero divisor");
   property p_idle_until_enable;
      !started_r |=> !baud.tick16;
   endproperty
   a_idle_until_enable: assert property (p_idle_until_enable) // [R05]
      else $error("generator ran before first enable");
   property p_tick_gap;
      baud.tick16 && div_r > 13'h0001 && $stable(div_r) |=> !baud.tick16;
   endproperty
   a_tick_gap: assert property (p_tick_gap) // [R04]
      else $error("ticks closer than divisor");
   property p_bit_tick;
      baud.tick_bit |-> baud.tick16 && $past(baud.tick16, 1) == 1'b0
         || $past(div_r) == 13'h0001;
   endproperty
   a_bit_tick: assert property (p_bit_tick) // [R12]
      else $error("bit tick off the oversample grid");
   property p_brk_irq;
      brk_r && hi_buf_r[BIT_BRK_IE] |-> irq_r;
   endproperty
   a_brk_irq: assert property (p_brk_irq) // [R06]
      else $error("break flag enabled but no interrupt");
   property p_edge_irq;
      edge_r && hi_buf_r[BIT_EDGE_IE] |-> irq_r;
   endproperty
   a_edge_irq: assert property (p_edge_irq) // [R07]
      else $error("edge flag enabled but no interrupt");
   property p_irq_quiet;
      !(brk_r && hi_buf_r[BIT_BRK_IE]) && !(edge_r && hi_buf_r[BIT_EDGE_IE])
         |-> !irq_r;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) // [R06] [R07]
      else $error("interrupt without enabled flag");
   property p_break_len;
      $rose(tx_state_r == SBR_TX_BREAK) |-> tx_cnt_r == TX_BRK_CNT
         && tx_line_r == $past(tx_invert_in) ##1 tx_cnt_r == TX_BRK_CNT;
   endproperty
   a_break_len: assert property (p_break_len) // [R08]
      else $error("break not thirteen bits");
   property p_frame_len;
      $rose(tx_state_r == SBR_TX_FRAME) |-> tx_cnt_r ==
         ($past(nine_bit_in) ? TX_FRM_CNT_9 : TX_FRM_CNT_8);
   endproperty
   a_frame_len: assert property (p_frame_len) // [R09]
      else $error("frame length wrong for character size");
   property p_parity;
      $rose(tx_state_r == SBR_TX_FRAME) && $past(parity_en_in) |->
         ($past(nine_bit_in) ? ^shift_r[9:1] : ^shift_r[8:1])
         == $past(parity_odd_in);
   endproperty
   a_parity: assert property (p_parity) // [R10]
      else $error("generated parity wrong");
   property p_polarity;
      (tx_state_r == SBR_TX_IDLE) [*2] ##0 $stable(tx_invert_in)
         |-> tx_line_r == !tx_invert_in;
   endproperty
   a_polarity: assert property (p_polarity) // [R11]
      else $error("idle level ignores polarity");
endmodule

// ===== tb/sbr_remote_node.sv
`timescale 1ns/10ps
module sbr_remote_node (
   // serial line toward the device
   output logic line_out
);
   // idle line rests at mark, as any nrz node leaves it
   initial line_out = 1'b1;
   // --------------------------------------------------------
   // frame and break senders
   // --------------------------------------------------------
   // lsb first: start, eight data bits, stop
   task automatic send_frame(input logic [7:0] data, input int bit_ns);
      logic [9:0] frame;
      frame = {1'b1, data, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_out = frame[i];
         #(bit_ns);
      end
   endtask
   // line held low for whole bit times, then back to mark
   task automatic send_break(input int bits, input int bit_ns);
      line_out = 1'b0;
      #(bits * bit_ns);
      line_out = 1'b1;
      #(bit_ns);
   endtask
endmodule

// ===== tb/sbr_baud_setup_test.sv
`timescale 1ns/10ps
module sbr_baud_setup_test;
   import sbr_pkg::*;
   logic clk_in, srst_in, reg_wr_in, reg_rd_in, ovr_seen;
   logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
   logic receiver_enable_in, transmitter_enable_in, nine_bit_in;
   logic parity_en_in, parity_odd_in, tx_invert_in, send_break_in;
   logic wake_addr_mark_in, rx_sleep_in, break_flag_clr_in;
   logic edge_flag_clr_in, tx_valid_in, tx_ready_out, rx_valid_out;
   logic rx_ready_in, rx_pin_in, tx_pin_out, break_detect_flag_out;
   logic rx_edge_flag_out, rx_overrun_out, irq_out;
   logic rx_frame_err_out, rx_parity_err_out;
   logic [8:0] tx_data_in, rx_data_out;
   int miscompares, cmp_count;
   sbr_baud_setup i_dut (.clk_in, .srst_in, .reg_addr_in, .reg_wr_in,
      .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .receiver_enable_in,
      .transmitter_enable_in, .nine_bit_in, .parity_en_in, .parity_odd_in,
      .tx_invert_in, .send_break_in, .wake_addr_mark_in, .rx_sleep_in,
      .break_flag_clr_in, .edge_flag_clr_in, .tx_data_in, .tx_valid_in,
      .tx_ready_out, .rx_data_out, .rx_parity_err_out, .rx_frame_err_out,
      .rx_valid_out, .rx_ready_in, .rx_pin_in, .tx_pin_out,
      .break_detect_flag_out, .rx_edge_flag_out, .rx_overrun_out, .irq_out);
   sbr_remote_node i_node (.line_out(rx_pin_in));
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   // overrun is a one-cycle pulse, so keep a sticky copy
   initial ovr_seen = 1'b0;
   always @(posedge clk_in) if (rx_overrun_out === 1'b1) ovr_seen <= 1'b1;
   // --------------------------------------------------------
   // shared tasks
   // --------------------------------------------------------
   task automatic check(input logic [8:0] got, input logic [8:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      #1;
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      cyc(1);
      reg_wr_in = 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      #1;
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      cyc(1);
      reg_rd_in = 1'b0;
      check({1'b0, reg_rdata_out}, {1'b0, exp});
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask
   task automatic conclude;
      $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
      if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // --------------------------------------------------------
   // scenarios
   // --------------------------------------------------------
   task automatic t_regs;
      rdc(OFF_DIV_HIGH, RST_DIV_HIGH);
      rdc(OFF_DIV_LOW, RST_DIV_LOW);
      wr(8'h42, 8'hff);
      rdc(8'h42, 8'h00);
      wr(OFF_DIV_HIGH, 8'hff);
      rdc(OFF_DIV_HIGH, 8'hc0);
      wr(OFF_DIV_LOW, 8'h01);
      rdc(OFF_DIV_HIGH, 8'hdf);
      rdc(OFF_DIV_LOW, 8'h01);
      wr(OFF_DIV_HIGH, 8'h00);
      wr(OFF_DIV_LOW, 8'h01);
   endtask
   // three frames into a two-word buffer with the reader stalled
   task automatic t_rx;
      receiver_enable_in = 1'b1;
      i_node.send_frame(8'ha5, 80);
      i_node.send_frame(8'h3c, 80);
      i_node.send_frame(8'h81, 80);
      cyc(20);
      check(ovr_seen, 1'b1);
      check(rx_edge_flag_out, 1'b1);
      check(rx_data_out, 9'h0a5);
      check(rx_frame_err_out, 1'b0);
      check(rx_parity_err_out, 1'b0);
      pulse(rx_ready_in);
      check(rx_data_out, 9'h03c);
      cyc(1);
      pulse(rx_ready_in);
      check(rx_valid_out, 1'b0);
   endtask
   task automatic t_irq;
      wr(OFF_DIV_HIGH, 8'h40);
      cyc(2);
      check(irq_out, 1'b1);
      wr(OFF_DIV_HIGH, 8'h00);
      cyc(2);
      check(irq_out, 1'b0);
      pulse(edge_flag_clr_in);
      wr(OFF_DIV_HIGH, 8'h80);
      i_node.send_break(12, 80);
      cyc(4);
      check(break_detect_flag_out, 1'b1);
      check(rx_frame_err_out, 1'b1);
      check(irq_out, 1'b1);
      pulse(break_flag_clr_in);
      cyc(2);
      check(irq_out, 1'b0);
   endtask
   // divisor 2, odd parity: each bit lasts 32 clocks, sampled mid-bit
   task automatic t_tx;
      logic [9:0] frame;
      // four ones in bits 6:0, so odd parity sets bit 7
      frame = {1'b1, 8'hb5, 1'b0};
      wr(OFF_DIV_LOW, 8'h02);
      parity_en_in = 1'b1;
      parity_odd_in = 1'b1;
      transmitter_enable_in = 1'b1;
      tx_data_in = 9'h035;
      tx_valid_in = 1'b1;
      for (int i = 0; i < 10 && tx_ready_out !== 1'b0; i++) cyc(1);
      tx_valid_in = 1'b0;
      for (int i = 0; i < 200 && tx_pin_out !== 1'b0; i++) cyc(1);
      cyc(16);
      for (int i = 0; i < 10; i++) begin
         check(tx_pin_out, frame[i]);
         cyc(32);
      end
      // inverted break: pin high for thirteen bits, then idles low
      tx_invert_in = 1'b1;
      send_break_in = 1'b1;
      cyc(40);
      check(tx_pin_out, 1'b1);
      send_break_in = 1'b0;
      cyc(420);
      check(tx_pin_out, 1'b0);
      tx_invert_in = 1'b0;
   endtask
   // zero divisor: the held word must never reach the pin
   task automatic t_zero;
      wr(OFF_DIV_LOW, 8'h00);
      tx_data_in = 9'h00f;
      tx_valid_in = 1'b1;
      for (int i = 0; i < 10 && tx_ready_out !== 1'b0; i++) cyc(1);
      tx_valid_in = 1'b0;
      cyc(300);
      check(tx_pin_out, 1'b1);
      check(tx_ready_out, 1'b0);
   endtask
   // --------------------------------------------------------
   // main sequence and watchdog
   // --------------------------------------------------------
   initial begin
      {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
      {receiver_enable_in, transmitter_enable_in, nine_bit_in} = '0;
      {parity_en_in, parity_odd_in, tx_invert_in, send_break_in} = '0;
      {wake_addr_mark_in, rx_sleep_in, break_flag_clr_in} = '0;
      {edge_flag_clr_in, tx_valid_in, tx_data_in, rx_ready_in} = '0;
      srst_in = 1'b1;
      cyc(10);
      srst_in = 1'b0;
      t_regs();
      t_rx();
      t_irq();
      t_tx();
      t_zero();
      conclude();
   end
   // whole run is a few thousand cycles; this is ample margin
   initial begin
      #200000;
      miscompares++;
      conclude();
   end
endmodule
